// *** src/irr_pkg.sv ***
// Constants and types shared by the infrared remote receiver files
package irr_pkg;

  // **********************************************************************
  // Timing
  // **********************************************************************
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned SAMPLE_PERIOD_NS = 30500;
  // Round-down style rounding: truncating division
  localparam int unsigned TICK_CYCLES      = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          TICK_W           = 10;
  localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(TICK_CYCLES - 1);

  // **********************************************************************
  // Widths and field layout of a finished frame
  // **********************************************************************
  localparam int DATA_BITS = 72;
  localparam int CNT_W     = 7;
  localparam int MEAS_W    = 9;
  localparam int NC_W      = 4;
  localparam int FR_CNT    = DATA_BITS;
  localparam int FR_LDR    = FR_CNT + CNT_W;
  localparam int FR_DMAX   = FR_LDR + 1;
  localparam int FR_LOW    = FR_DMAX + 1;
  localparam int FRAME_W   = FR_LOW + 1;
  localparam int BUF1_LSB  = 0;
  localparam int BUF2_LSB  = 32;
  localparam int BUF3_LSB  = 64;

  localparam logic [MEAS_W-1:0] MEAS_MAX      = 9'h01ff;
  localparam logic [CNT_W-1:0]  CNT_MAX       = 7'h7f;
  localparam logic [7:0]        LOW_ONLY_CODE = 8'h00;
  localparam logic [NC_W-1:0]   NC_ZERO       = 4'h0;

  typedef enum logic [4:0] {
    IRR_IDLE     = 5'h01,
    IRR_LDR_LOW  = 5'h02,
    IRR_LDR_HIGH = 5'h04,
    IRR_DATA     = 5'h08,
    IRR_PUSH     = 5'h10
  } irr_state_e;

  typedef enum logic [2:0] {
    IRR_PAT_ONE   = 3'h1,
    IRR_PAT_ONEHF = 3'h2,
    IRR_PAT_TWO   = 3'h4
  } irr_pat_e;

endpackage

// *** src/irr_skid_buf.sv ***
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/100ps
module irr_skid_buf import irr_pkg::*; #(
  parameter int unsigned WIDTH = FRAME_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);

  logic             skid_valid;
  logic [WIDTH-1:0] skid_data;
  logic             push;
  logic             out_free;

  assign push     = i_valid & o_ready;
  assign out_free = ~o_valid | i_ready;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_valid    <= 1'b0;
      o_data     <= '0;
      skid_valid <= 1'b0;
      skid_data  <= '0;
      o_ready    <= 1'b1;
    end else if (out_free) begin
      // Older skid word always leaves first to keep order
      if (skid_valid) begin
        o_valid    <= 1'b1;
        o_data     <= skid_data;
        skid_valid <= push;
        if (push) begin
          skid_data <= i_data;
        end
        o_ready    <= ~push;
      end else begin
        o_valid <= push;
        if (push) begin
          o_data <= i_data;
        end
        o_ready <= 1'b1;
      end
    end else if (push) begin
      skid_valid <= 1'b1;
      skid_data  <= i_data;
      o_ready    <= 1'b0;
    end
  end

endmodule

// *** src/irr_receiver.sv ***
// Infrared remote receiver: leader, leaderless, low-only leader and phase decoding
// Notes on behaviour
// - Leaderless on: low shorter than leader low max but outside the leader low range starts data until frame end.
// - Leader and leaderless frames share error, end and bit decisions.
// - Low-only leader configuration ignores the leader low minimum.
// - Each pulse distance bit is resolved against the 7-bit low threshold; phase bits also use the high threshold.
// - Max bit cycle or excess low ends frame, pulses event, back to idle.
// - Phase mode select one decodes phase signals instead of pulse distance.
// - Phase falling intervals are one, one and a half, or two base cycles.
// - Low threshold splits patterns one/one and a half, high threshold splits one and a half/two.
// - Phase bit value comes from pattern and previous bit.
// - Phase bits land in the three receive buffers at frame end.
// - Phase decoding assumes a fixed base period.
// - Pulse distance: cycle above low threshold gives one, else zero.
// - No falling edge within max bit cycle ends the frame.
// - Low lasting past the excess low limit after a fall ends the frame.
`timescale 1ns/100ps
module irr_receiver import irr_pkg::*; (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_rx_pin,
  input  wire logic             i_enable,
  input  wire logic             i_leaderless_enable,
  input  wire logic             i_input_polarity_invert,
  input  wire logic             i_phase_mode_select,
  input  wire logic [NC_W-1:0]  i_noise_cycles,
  input  wire logic [7:0]       i_leader_low_max,
  input  wire logic [7:0]       i_leader_low_min,
  input  wire logic [7:0]       i_leader_high_max,
  input  wire logic [7:0]       i_leader_high_min,
  input  wire logic [6:0]       i_bit_threshold_low,
  input  wire logic [6:0]       i_bit_threshold_high,
  input  wire logic [7:0]       i_max_bit_cycle,
  input  wire logic [7:0]       i_excess_low_limit,
  input  wire logic             i_frame_ready,
  output logic                  o_frame_valid,
  output logic      [31:0]      o_rx_buffer_one,
  output logic      [31:0]      o_rx_buffer_two,
  output logic      [7:0]       o_rx_buffer_three,
  output logic      [CNT_W-1:0] o_bit_count,
  output logic                  o_frame_had_leader,
  output logic                  o_end_max_cycle,
  output logic                  o_end_low_excess,
  output logic                  o_frame_end,
  output logic                  o_receiving
);

  // **********************************************************************
  // Helpers
  // **********************************************************************
  function automatic logic [MEAS_W-1:0] sat_inc(input logic [MEAS_W-1:0] v);
    sat_inc = (v == MEAS_MAX) ? v : MEAS_W'(v + 1'b1);
  endfunction

  function automatic logic [MEAS_W-1:0] widen8(input logic [7:0] v);
    widen8 = {1'b0, v};
  endfunction

  function automatic logic [MEAS_W-1:0] widen7(input logic [6:0] v);
    widen7 = {2'b00, v};
  endfunction

  // **********************************************************************
  // Sampling tick, synchroniser and noise filter
  // **********************************************************************
  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic              rx_meta;
  logic              rx_sync;
  logic              level;
  logic              flt;
  logic [NC_W-1:0]   nc_cnt;
  logic              fall_p;
  logic              rise_p;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : TICK_W'(tick_cnt + 1'b1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= i_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  assign level = rx_sync ^ i_input_polarity_invert;

  // A new level is taken after enough steady ticks of it
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flt    <= 1'b1;
      nc_cnt <= '0;
      fall_p <= 1'b0;
      rise_p <= 1'b0;
    end else begin
      fall_p <= 1'b0;
      rise_p <= 1'b0;
      if (tick) begin
        if (level == flt) begin
          nc_cnt <= '0;
        end else if (NC_W'(nc_cnt + 1'b1) >= i_noise_cycles || i_noise_cycles == NC_ZERO) begin
          flt    <= level;
          nc_cnt <= '0;
          fall_p <= ~level;
          rise_p <= level;
        end else begin
          nc_cnt <= NC_W'(nc_cnt + 1'b1);
        end
      end
    end
  end

  // **********************************************************************
  // Width and cycle counters
  // **********************************************************************
  logic [MEAS_W-1:0] cyc;
  logic [MEAS_W-1:0] wid;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cyc <= '0;
      wid <= '0;
    end else begin
      if (fall_p) begin
        cyc <= '0;
      end else if (tick) begin
        cyc <= sat_inc(cyc);
      end
      if (fall_p | rise_p) begin
        wid <= '0;
      end else if (tick) begin
        wid <= sat_inc(wid);
      end
    end
  end

  // **********************************************************************
  // Decision terms
  // **********************************************************************
  irr_state_e state;
  logic       low_only;
  logic       low_in_range;
  logic       high_in_range;
  logic       end_dmax;
  logic       end_low;
  logic       ending;
  logic       prev_bit;
  logic       buf_ready;
  irr_pat_e   pat;
  logic [1:0] emit_bits;
  logic       emit_two;

  assign low_only      = (i_leader_low_max == LOW_ONLY_CODE);
  assign low_in_range  = wid >= widen8(i_leader_low_min) && wid <= widen8(i_leader_low_max);
  assign high_in_range = wid >= widen8(i_leader_high_min) && wid <= widen8(i_leader_high_max);
  assign end_dmax      = cyc > widen8(i_max_bit_cycle);
  assign end_low       = ~flt && cyc > widen8(i_excess_low_limit);
  assign ending        = end_dmax | end_low;

  // Only a steady base period keeps the three bands apart
  always_comb begin
    if (cyc <= widen7(i_bit_threshold_low)) begin
      pat = IRR_PAT_ONE;
    end else if (cyc <= widen7(i_bit_threshold_high)) begin
      pat = IRR_PAT_ONEHF;
    end else begin
      pat = IRR_PAT_TWO;
    end
  end

  // Shared by frames with and without a leader
  always_comb begin
    emit_two  = 1'b0;
    emit_bits = 2'b00;
    if (!i_phase_mode_select) begin
      emit_bits = {1'b0, cyc > widen7(i_bit_threshold_low)};
    end else begin
      unique case (pat)
        IRR_PAT_ONE: begin
          emit_bits = {1'b0, prev_bit};
        end
        IRR_PAT_ONEHF: begin
          emit_two  = prev_bit;
          emit_bits = prev_bit ? 2'b00 : 2'b01;
        end
        IRR_PAT_TWO: begin
          emit_two  = prev_bit;
          emit_bits = 2'b01;
        end
      endcase
    end
  end

  // **********************************************************************
  // Frame sequencer
  // **********************************************************************
  logic [DATA_BITS-1:0] shreg;
  logic [CNT_W-1:0]     nbits;
  logic                 leader;
  logic                 why_dmax;
  logic                 why_low;

  always_ff @(posedge i_clk) begin
    if (i_srst || !i_enable) begin
      // Disabling drops a frame in progress
      state       <= IRR_IDLE;
      shreg       <= '0;
      nbits       <= '0;
      leader      <= 1'b0;
      why_dmax    <= 1'b0;
      why_low     <= 1'b0;
      prev_bit    <= 1'b1;
      o_frame_end <= 1'b0;
      o_receiving <= 1'b0;
    end else begin
      o_frame_end <= 1'b0;
      unique case (state)
        IRR_IDLE: begin
          shreg    <= '0;
          nbits    <= '0;
          leader   <= 1'b0;
          prev_bit <= 1'b1;
          if (fall_p) begin
            state <= IRR_LDR_LOW;
          end
        end
        IRR_LDR_LOW: begin
          if (rise_p) begin
            if (low_only || low_in_range) begin
              state <= IRR_LDR_HIGH;
            end else if (i_leaderless_enable && wid < widen8(i_leader_low_max)) begin
              state       <= IRR_DATA;
              o_receiving <= 1'b1;
            end else begin
              state <= IRR_IDLE;
            end
          end
        end
        IRR_LDR_HIGH: begin
          if (fall_p) begin
            state       <= high_in_range ? IRR_DATA : IRR_IDLE;
            leader      <= high_in_range;
            o_receiving <= high_in_range;
          end else if (wid == MEAS_MAX) begin
            state <= IRR_IDLE;
          end
        end
        IRR_DATA: begin
          if (ending) begin
            state       <= IRR_PUSH;
            why_dmax    <= end_dmax;
            why_low     <= end_low;
            o_frame_end <= 1'b1;
            o_receiving <= 1'b0;
          end else if (fall_p) begin
            if (emit_two) begin
              shreg <= {shreg[DATA_BITS-3:0], emit_bits};
              nbits <= (nbits >= CNT_MAX - 7'h01) ? CNT_MAX : CNT_W'(nbits + 7'h02);
            end else begin
              shreg <= {shreg[DATA_BITS-2:0], emit_bits[0]};
              nbits <= (nbits == CNT_MAX) ? CNT_MAX : CNT_W'(nbits + 7'h01);
            end
            prev_bit <= emit_bits[0];
          end
        end
        IRR_PUSH: begin
          // Holding here stalls reception while the buffer is full
          if (buf_ready) begin
            state <= IRR_IDLE;
          end
        end
      endcase
    end
  end

  // **********************************************************************
  // Result buffer
  // **********************************************************************
  logic [FRAME_W-1:0] frame_in;
  logic [FRAME_W-1:0] frame_out;

  assign frame_in = {why_low, why_dmax, leader, nbits, shreg};

  irr_skid_buf #(
    .WIDTH (FRAME_W)
  ) u_buf (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (state == IRR_PUSH),
    .o_ready (buf_ready),
    .i_data  (frame_in),
    .o_valid (o_frame_valid),
    .i_ready (i_frame_ready),
    .o_data  (frame_out)
  );

  assign o_rx_buffer_one    = frame_out[BUF1_LSB +: 32];
  assign o_rx_buffer_two    = frame_out[BUF2_LSB +: 32];
  assign o_rx_buffer_three  = frame_out[BUF3_LSB +: 8];
  assign o_bit_count        = frame_out[FR_CNT +: CNT_W];
  assign o_frame_had_leader = frame_out[FR_LDR];
  assign o_end_max_cycle    = frame_out[FR_DMAX];
  assign o_end_low_excess   = frame_out[FR_LOW];

  // **********************************************************************
  // Checks
  // **********************************************************************
  AST_END_ON_DMAX: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_DATA && end_dmax) ##1 i_enable |-> state == IRR_PUSH && why_dmax)
    else $error("Max bit cycle did not end the frame");

  AST_END_ON_LOW: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_DATA && end_low) ##1 i_enable |-> state == IRR_PUSH && why_low)
    else $error("Excess low did not end the frame");

  AST_END_EVENT: assert property (@(posedge i_clk) disable iff (i_srst)
    o_frame_end |-> state == IRR_PUSH && $past(state) == IRR_DATA ##1 !o_frame_end)
    else $error("Frame end pulse out of step with the sequencer");

  AST_PD_BIT: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_DATA && fall_p && !ending && !i_phase_mode_select) ##1 i_enable
      |-> shreg[0] == ($past(cyc) > widen7($past(i_bit_threshold_low))))
    else $error("Pulse distance bit disagrees with low threshold");

  AST_LOW_ONLY: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_LDR_LOW && rise_p && low_only) ##1 i_enable |-> state == IRR_LDR_HIGH)
    else $error("Low-only leader was not accepted");

  AST_LEADERLESS: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_LDR_LOW && rise_p && !low_only && !low_in_range && i_leaderless_enable
      && wid < widen8(i_leader_low_max)) ##1 i_enable |-> state == IRR_DATA && !leader && o_receiving)
    else $error("Leaderless frame did not start");

  AST_PHASE_SAME: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_DATA && fall_p && !ending && i_phase_mode_select
      && cyc <= widen7(i_bit_threshold_low)) ##1 i_enable |-> shreg[0] == $past(prev_bit))
    else $error("Short phase interval did not repeat previous bit");

  AST_PHASE_LONG: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_DATA && fall_p && !ending && i_phase_mode_select && prev_bit
      && cyc > widen7(i_bit_threshold_high)) ##1 i_enable |-> shreg[1:0] == 2'b01)
    else $error("Long phase interval after one did not give zero then one");

  AST_PUSH_OUT: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_enable && state == IRR_PUSH && buf_ready) ##1 i_enable |-> state == IRR_IDLE ##1 o_frame_valid)
    else $error("Finished frame not handed to the buffer");

endmodule

// *** tb/irr_ir_source.sv ***
// Behavioural infrared source that drives the demodulated receiver pin
`timescale 1ns/100ps
module irr_ir_source import irr_pkg::*; (
  input  wire logic i_clk,
  input  wire logic i_invert,
  output logic      o_pin
);
  // **********************************************************************
  // Line level
  // **********************************************************************
  // Idle high, like a receiver module output with its pull-up
  logic level = 1'b1;

  assign o_pin = level ^ i_invert;

  // Whole ticks only, so the base period never drifts
  task automatic hold(input logic lvl, input int ticks);
    level = lvl;
    repeat (ticks * TICK_CYCLES) @(negedge i_clk);
  endtask

  task automatic pulse(input int low_t, input int high_t);
    hold(1'b0, low_t);
    hold(1'b1, high_t);
  endtask
endmodule

// *** tb/irr_receiver_bench.sv ***
// Self-checking bench for the infrared remote receiver
`timescale 1ns/100ps
module irr_receiver_bench import irr_pkg::*;;
  // **********************************************************************
  // Signals
  // **********************************************************************
  typedef struct packed {
    logic [71:0] bits;
    logic [6:0]  cnt;
    logic        ldr;
    logic        dmax;
    logic        low;
  } irr_exp_s;

  logic        clk;
  logic        srst;
  logic        pin;
  logic        enable;
  logic        leaderless;
  logic        invert;
  logic        phase;
  logic [3:0]  noise;
  logic [7:0]  ll_max;
  logic [7:0]  ll_min;
  logic [7:0]  lh_max;
  logic [7:0]  lh_min;
  logic [6:0]  th_lo;
  logic [6:0]  th_hi;
  logic [7:0]  max_cyc;
  logic [7:0]  low_lim;
  logic        ready;
  logic        frame_valid;
  logic [31:0] buf_one;
  logic [31:0] buf_two;
  logic [7:0]  buf_three;
  logic [6:0]  bit_count;
  logic        had_leader;
  logic        end_max;
  logic        end_low;
  logic        frame_end;
  logic        receiving;
  int          fails    = 0;
  int          n_checks = 0;
  int          n_ends   = 0;
  int          n_frames = 0;
  irr_exp_s    exp_q[$];

  irr_ir_source src (.i_clk(clk), .i_invert(invert), .o_pin(pin));

  irr_receiver DUT (
    .i_clk(clk), .i_srst(srst), .i_rx_pin(pin), .i_enable(enable),
    .i_leaderless_enable(leaderless), .i_input_polarity_invert(invert),
    .i_phase_mode_select(phase), .i_noise_cycles(noise),
    .i_leader_low_max(ll_max), .i_leader_low_min(ll_min),
    .i_leader_high_max(lh_max), .i_leader_high_min(lh_min),
    .i_bit_threshold_low(th_lo), .i_bit_threshold_high(th_hi),
    .i_max_bit_cycle(max_cyc), .i_excess_low_limit(low_lim),
    .i_frame_ready(ready), .o_frame_valid(frame_valid),
    .o_rx_buffer_one(buf_one), .o_rx_buffer_two(buf_two),
    .o_rx_buffer_three(buf_three), .o_bit_count(bit_count),
    .o_frame_had_leader(had_leader), .o_end_max_cycle(end_max),
    .o_end_low_excess(end_low), .o_frame_end(frame_end),
    .o_receiving(receiving)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk) begin
    if (frame_end === 1'b1) n_ends <= n_ends + 1;
  end

  // **********************************************************************
  // Helpers
  // **********************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [71:0] got, input logic [71:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, want);
    end
  endtask

  function automatic void push(inout irr_exp_s e, input logic b);
    e.bits = {e.bits[70:0], b};
    if (e.cnt != 7'h7f) e.cnt++;
  endfunction

  // Bits that one falling-edge interval yields
  function automatic void decode(inout irr_exp_s e, inout logic prev, input bit phs, input int cyc);
    if (!phs) push(e, cyc > int'(th_lo));
    else if (cyc <= int'(th_lo)) push(e, prev);
    else if (cyc <= int'(th_hi)) begin
      if (prev) begin
        push(e, 1'b0);
        push(e, 1'b0);
      end
      else push(e, 1'b1);
    end
    else begin
      if (prev) push(e, 1'b0);
      push(e, 1'b1);
    end
    prev = e.bits[0];
  endfunction

  task automatic send_frame(input bit ldr, input bit phs, input bit lo_end, input int n, input string name);
    irr_exp_s e;
    logic     prev;
    int       cyc;
    e = '0;
    prev = 1'b1;
    if (ldr) src.pulse(6, 3);
    for (int i = 0; i < n; i++) begin
      // Corner: a first long interval right after the start bit
      if (phs) cyc = (i == 0) ? 8 : 4 + 2 * int'($urandom % 3);
      else cyc = ($urandom % 2) ? 5 : 2;
      src.pulse(1, cyc - 1);
      if (i == 0) check(72'(receiving), 72'h1, "receiving");
      decode(e, prev, phs, cyc);
    end
    if (lo_end) begin
      src.hold(1'b0, 10);
      src.hold(1'b1, 2);
    end
    else src.pulse(1, 12);
    n_frames++;
    check(72'(n_ends), 72'(n_frames), "frame end pulses");
    check(72'(receiving), 72'h0, "idle after end");
    e.ldr = ldr;
    e.dmax = !lo_end;
    e.low = lo_end;
    exp_q.push_back(e);
    $display("test %s done", name);
  endtask

  task automatic pop_check();
    irr_exp_s e;
    int       n;
    e = exp_q.pop_front();
    n = 0;
    while (!(frame_valid === 1'b1) && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(72'(frame_valid), 72'h1, "frame valid");
    check(72'(buf_one), 72'(e.bits[31:0]), "buffer one");
    check(72'(buf_two), 72'(e.bits[63:32]), "buffer two");
    check(72'(buf_three), 72'(e.bits[71:64]), "buffer three");
    check(72'(bit_count), 72'(e.cnt), "bit count");
    check(72'({had_leader, end_max, end_low}), 72'({e.ldr, e.dmax, e.low}), "flags");
    ready = 1'b1;
    @(negedge clk);
    ready = 1'b0;
    @(negedge clk);
  endtask

  // **********************************************************************
  // Sequence
  // **********************************************************************
  initial begin
    srst = 1'b1;
    enable = 1'b1;
    leaderless = 1'b0;
    invert = 1'b0;
    phase = 1'b0;
    noise = 4'h1;
    ll_max = 8'h08;
    ll_min = 8'h04;
    lh_max = 8'h05;
    lh_min = 8'h02;
    th_lo = 7'h03;
    th_hi = 7'h07;
    max_cyc = 8'h08;
    low_lim = 8'h08;
    ready = 1'b0;
    void'($urandom(15));
    repeat (6) @(negedge clk);
    srst = 1'b0;
    src.hold(1'b1, 2);
    send_frame(1'b1, 1'b0, 1'b0, 3, "leader pulse distance");
    leaderless = 1'b1;
    low_lim = 8'h06;
    // Second frame lands while the first still waits unread
    send_frame(1'b0, 1'b0, 1'b1, 3, "leaderless low end");
    pop_check();
    leaderless = 1'b0;
    phase = 1'b1;
    th_lo = 7'h05;
    max_cyc = 8'h0a;
    low_lim = 8'h0c;
    send_frame(1'b1, 1'b1, 1'b0, 3, "phase");
    pop_check();
    pop_check();
    phase = 1'b0;
    th_lo = 7'h03;
    max_cyc = 8'h08;
    invert = 1'b1;
    ll_max = 8'h00;
    ll_min = 8'hff;
    send_frame(1'b1, 1'b0, 1'b0, 3, "low only leader");
    pop_check();
    give_verdict();
  end

  // Frames take between about seventy and ninety-one thousand clocks in all
  initial begin
    repeat (105000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
